// File: rtl/bpc_port.sv
/*
 * bidirectional gpio port with interrupt on change, apb slave
 * assumes: apb master on clk; pins resolved outside from out/oe_b
 */
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "bpc_defines.svh"

// Overview of operation
// - port has direction, pin-level and output latch registers; one port instanced here
// - enabled alternate peripheral takes the pin away from general-purpose use
// - six-bit port; the input-only pin's direction bit always reads one
// - direction bit one makes the pin an input, driver off
// - direction bit zero drives the output latch onto the pin
// - pin-level read returns pin levels; write updates the output latch
// - output latch register readable, returns latched value, not pins
// - per-pin change-enable bit turns change detection on or off
// - global change-enable gates all pin change interrupts
// - only pins set as inputs take part in change compare
// - compare current level with copy latched at last pin-level read
// - per-pin mismatches ORed set the shared change flag
module bpc_port
    import bpc_pkg::*;
#(
    parameter int WIDTH = 6
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // pins
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe_b,
    // alternate peripheral functions
    input  wire logic [WIDTH-1:0] alt_out,
    input  wire logic [WIDTH-1:0] alt_oe_b,
    // interrupt
    output logic                  irq
);
    // ***************************************************************
    // reset release
    // ***************************************************************
    logic [1:0] rst_q;
    logic       rst_s_b;

    // two-stage release of reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_s_b = rst_q[1];

    // ***************************************************************
    // pin synchroniser
    // ***************************************************************
    logic [WIDTH-1:0] pin_level;

    bpc_sync #(
        .WIDTH (WIDTH)
    ) u_sync (
        .clk   (clk),
        .rst_b (rst_s_b),
        .din   (pin_in),
        .dout  (pin_level)
    );

    // ***************************************************************
    // state
    // ***************************************************************
    // direction, level, latch
    typedef struct packed {
        bpc_phase_t       phase;
        logic [WIDTH-1:0] direction_bits;
        logic [WIDTH-1:0] output_latch;
        logic [WIDTH-1:0] change_enable_reg;
        logic [WIDTH-1:0] alt_en;
        logic [WIDTH-1:0] read_copy;
        logic             change_irq_global_enable;
        logic             change_irq_flag;
        logic             irq_en;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        logic [WIDTH-1:0] pin_out;
        logic [WIDTH-1:0] pin_oe_b;
        logic             irq;
    } bpc_state_t;

    bpc_state_t st;
    bpc_state_t next_st;

    // direction as seen by software and logic, input-only pin forced
    function automatic logic [WIDTH-1:0] eff_dir(input logic [WIDTH-1:0] d);
        logic [WIDTH-1:0] r;
        r                 = d;
        r[`BPC_INPUT_ONLY] = 1'b1;
        return r;
    endfunction

    logic [WIDTH-1:0] dir_now;
    logic [WIDTH-1:0] mismatch;
    logic             change_evt;
    logic             wr;
    logic             rd;
    logic             hit;

    assign dir_now    = eff_dir(st.direction_bits);
    assign mismatch   = (pin_level ^ st.read_copy) & st.change_enable_reg & dir_now;
    assign change_evt = (|mismatch) & st.change_irq_global_enable;
    assign wr         = psel && penable && st.phase == BPC_ACCESS && pwrite;
    assign rd         = psel && penable && st.phase == BPC_ACCESS && !pwrite;
    assign hit        = paddr inside {`BPC_OFF_DIR, `BPC_OFF_LEVEL, `BPC_OFF_LATCH,
                                      `BPC_OFF_CHG_EN, `BPC_OFF_CTRL, `BPC_OFF_IRQ_STAT,
                                      `BPC_OFF_IRQ_CLR, `BPC_OFF_IRQ_EN, `BPC_OFF_ALT_EN};

    // ***************************************************************
    // next-state logic
    // ***************************************************************
    always_comb begin
        next_st         = st;
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        // apb: setup then one wait cycle, answer registered
        case (st.phase)
            BPC_IDLE: begin
                if (psel && !penable) begin
                    next_st.phase = BPC_ACCESS;
                end
            end
            BPC_ACCESS: begin
                if (!st.pready) begin
                    next_st.pready  = 1'b1;
                    next_st.pslverr = !hit;
                    next_st.prdata  = 32'h0000_0000;
                    if (!pwrite) begin
                        case (paddr)
                            `BPC_OFF_DIR:      next_st.prdata[WIDTH-1:0] = dir_now;
                            `BPC_OFF_LEVEL:    next_st.prdata[WIDTH-1:0] = pin_level;
                            `BPC_OFF_LATCH:    next_st.prdata[WIDTH-1:0] = st.output_latch;
                            `BPC_OFF_CHG_EN:   next_st.prdata[WIDTH-1:0] = st.change_enable_reg;
                            `BPC_OFF_CTRL: begin
                                next_st.prdata[`BPC_CTRL_GIE_BIT]  = st.change_irq_global_enable;
                                next_st.prdata[`BPC_CTRL_FLAG_BIT] = st.change_irq_flag;
                            end
                            `BPC_OFF_IRQ_STAT: next_st.prdata[`BPC_IRQ_CHG_BIT] = st.change_irq_flag;
                            `BPC_OFF_IRQ_EN:   next_st.prdata[`BPC_IRQ_CHG_BIT] = st.irq_en;
                            `BPC_OFF_ALT_EN:   next_st.prdata[WIDTH-1:0] = st.alt_en;
                            default:           next_st.prdata = 32'h0000_0000;
                        endcase
                    end
                end else begin
                    next_st.phase = BPC_IDLE;
                end
            end
            default: next_st.phase = BPC_IDLE;
        endcase

        // register writes take effect on the pready edge
        if (wr && st.pready) begin
            case (paddr)
                `BPC_OFF_DIR:    next_st.direction_bits = pwdata[WIDTH-1:0];
                `BPC_OFF_LEVEL:  next_st.output_latch = pwdata[WIDTH-1:0];
                `BPC_OFF_LATCH:  next_st.output_latch = pwdata[WIDTH-1:0];
                `BPC_OFF_CHG_EN: next_st.change_enable_reg = pwdata[WIDTH-1:0];
                `BPC_OFF_CTRL: begin
                    next_st.change_irq_global_enable = pwdata[`BPC_CTRL_GIE_BIT];
                    if (!pwdata[`BPC_CTRL_FLAG_BIT]) begin
                        next_st.change_irq_flag = 1'b0;
                    end
                end
                `BPC_OFF_IRQ_CLR: begin
                    if (pwdata[`BPC_IRQ_CHG_BIT]) begin
                        next_st.change_irq_flag = 1'b0;
                    end
                end
                `BPC_OFF_IRQ_EN: next_st.irq_en = pwdata[`BPC_IRQ_CHG_BIT];
                `BPC_OFF_ALT_EN: next_st.alt_en = pwdata[WIDTH-1:0];
                default: ;
            endcase
        end

        if (rd && st.pready && paddr == `BPC_OFF_LEVEL) begin
            next_st.read_copy = st.prdata[WIDTH-1:0]; // the very value software was handed
        end

        // sticky flag, set wins over clear
        if (change_evt) begin
            next_st.change_irq_flag = 1'b1;
        end

        // pin drive per bit
        for (int i = 0; i < WIDTH; i++) begin
            if (st.alt_en[i]) begin
                next_st.pin_out[i]  = alt_out[i];
                next_st.pin_oe_b[i] = alt_oe_b[i] | (i == `BPC_INPUT_ONLY);
            end else begin
                next_st.pin_out[i]  = st.output_latch[i];
                next_st.pin_oe_b[i] = dir_now[i];
            end
        end

        next_st.irq = next_st.change_irq_flag & next_st.irq_en;
    end

    // state register
    always_ff @(posedge clk or negedge rst_s_b) begin
        if (!rst_s_b) begin
            st                <= '0;
            st.direction_bits <= `BPC_DIR_RST;
            st.pin_oe_b       <= `BPC_DIR_RST;
            st.output_latch   <= `BPC_LATCH_RST;
        end else begin
            st <= next_st;
        end
    end

    assign prdata   = st.prdata;
    assign pready   = st.pready;
    assign pslverr  = st.pslverr;
    assign pin_out  = st.pin_out;
    assign pin_oe_b = st.pin_oe_b;
    assign irq      = st.irq;

    // ***************************************************************
    // checks
    // ***************************************************************
    chk_flag_sticky: assert property (@(posedge clk) disable iff (!rst_s_b)
        st.change_irq_flag && !(wr && st.pready) |=> st.change_irq_flag)
        else $error("change flag dropped without a clear");

    chk_change_sets: assert property (@(posedge clk) disable iff (!rst_s_b)
        change_evt |=> st.change_irq_flag)
        else $error("mismatch did not set change flag");

    chk_gie_gates: assert property (@(posedge clk) disable iff (!rst_s_b)
        !st.change_irq_global_enable && !st.change_irq_flag |=> !st.change_irq_flag)
        else $error("change flag set with global enable clear");

    chk_output_excl: assert property (@(posedge clk) disable iff (!rst_s_b)
        !st.change_irq_flag && ((pin_level ^ st.read_copy) & st.change_enable_reg
        & (st.direction_bits | (WIDTH'(1) << `BPC_INPUT_ONLY))) == '0 |=> !st.change_irq_flag)
        else $error("output pin set the change flag");

    chk_pin_enable: assert property (@(posedge clk) disable iff (!rst_s_b)
        !st.change_irq_flag && ((pin_level ^ st.read_copy) & st.change_enable_reg) == '0
        |=> !st.change_irq_flag)
        else $error("disabled pin set the change flag");

    chk_dir_drive: assert property (@(posedge clk) disable iff (!rst_s_b)
        1'b1 |=> ((st.pin_oe_b ^ $past(dir_now)) & ~$past(st.alt_en)) == '0)
        else $error("pin driver does not follow direction");

    chk_alt_owns: assert property (@(posedge clk) disable iff (!rst_s_b)
        1'b1 |=> ((st.pin_out ^ $past(alt_out)) & $past(st.alt_en)) == '0)
        else $error("alternate function does not own its pin");

    chk_write_latch: assert property (@(posedge clk) disable iff (!rst_s_b)
        wr && st.pready && paddr == `BPC_OFF_LEVEL
        |=> st.output_latch == $past(pwdata[WIDTH-1:0]))
        else $error("pin-level write missed the latch");

    chk_ready_pulse: assert property (@(posedge clk) disable iff (!rst_s_b)
        st.pready |=> !st.pready)
        else $error("pready held longer than one cycle");

    chk_input_only: assert property (@(posedge clk) disable iff (!rst_s_b)
        st.pin_oe_b[`BPC_INPUT_ONLY])
        else $error("input-only pin driven");

    chk_drive_latch: assert property (@(posedge clk) disable iff (!rst_s_b)
        !st.alt_en[0] && !dir_now[0] |=> st.pin_out[0] == $past(st.output_latch[0]))
        else $error("pin zero not driving latch");

    chk_read_copy: assert property (@(posedge clk) disable iff (!rst_s_b)
        rd && st.pready && paddr == `BPC_OFF_LEVEL
        |=> st.read_copy == $past(st.prdata[WIDTH-1:0]))
        else $error("read copy not refreshed");

    chk_latch_read: assert property (@(posedge clk) disable iff (!rst_s_b)
        st.phase == BPC_ACCESS && !st.pready && !pwrite && paddr == `BPC_OFF_LATCH
        |=> st.prdata[WIDTH-1:0] == $past(st.output_latch))
        else $error("latch read returned wrong value");
endmodule

// File: rtl/bpc_defines.svh
/*
 * register offsets, field positions, reset values for the gpio port block
 * assumes: included by bare name inside design files
 */
`ifndef BPC_DEFINES_SVH
`define BPC_DEFINES_SVH

// ***************************************************************
// register byte offsets (apb, one aligned word each)
// ***************************************************************
`define BPC_OFF_DIR      12'h000
`define BPC_OFF_LEVEL    12'h004
`define BPC_OFF_LATCH    12'h008
`define BPC_OFF_CHG_EN   12'h00C
`define BPC_OFF_CTRL     12'h010
`define BPC_OFF_IRQ_STAT 12'h014
`define BPC_OFF_IRQ_CLR  12'h018
`define BPC_OFF_IRQ_EN   12'h01C
`define BPC_OFF_ALT_EN   12'h020

// ***************************************************************
// field positions and reset values
// ***************************************************************
`define BPC_CTRL_GIE_BIT  0
`define BPC_CTRL_FLAG_BIT 1
`define BPC_IRQ_CHG_BIT   0
`define BPC_INPUT_ONLY    3
`define BPC_DIR_RST       6'h3F
`define BPC_LATCH_RST     6'h00

`endif

// File: rtl/bpc_pkg.sv
/*
 * types shared by the gpio port block
 * assumes: nothing beyond a systemverilog compiler
 */
package bpc_pkg;
    // ***************************************************************
    // apb access phases
    // ***************************************************************
    typedef enum logic [0:0] {
        BPC_IDLE,
        BPC_ACCESS
    } bpc_phase_t;
endpackage

// File: rtl/bpc_sync.sv
/*
 * three-stage synchroniser for the pin levels, change counts once
 * stages two and three agree
 * assumes: pins are asynchronous to clk
 */
`timescale 1ns/1ns
module bpc_sync #(
    parameter int WIDTH = 6
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // pins in, filtered levels out
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } bpc_sync_st_t;

    bpc_sync_st_t st;
    bpc_sync_st_t next_st;

    // shift chain, accept when second and third stage agree
    always_comb begin
        next_st    = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.q;
endmodule

// File: verification/bpc_pin_model.sv
/*
 * pin-side model of the port: resolves each package pin level
 * assumes: design drive wins, then the external source, else a pull-up
 */
`timescale 1ns/1ns
module bpc_pin_model #(
    parameter int WIDTH = 6
) (
    // design side
    input  wire logic [WIDTH-1:0] pin_out,
    input  wire logic [WIDTH-1:0] pin_oe_b,
    // external source
    input  wire logic [WIDTH-1:0] ext_val,
    input  wire logic [WIDTH-1:0] ext_oe_b,
    // resolved level
    output logic      [WIDTH-1:0] pin_in
);
    // ***************************************************************
    // pin resolution
    // ***************************************************************
    // driver wins
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            pin_in[i] = !pin_oe_b[i] ? pin_out[i] : (!ext_oe_b[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule

// File: verification/bpc_port_tb.sv
/*
 * self-checking bench for the gpio port: apb master, pin source, scenarios
 * assumes: master waits for pready, pins resolved by bpc_pin_model
 */
`timescale 1ns/1ns
`include "bpc_defines.svh"
module bpc_port_tb;
    // ***************************************************************
    // signals
    // ***************************************************************
    logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic        pready, pslverr, irq, rerr;
    logic [5:0]  pin_in, pin_out, pin_oe_b, alt_out = 6'h00, alt_oe_b = 6'h3F;
    logic [5:0]  ext_val = 6'h00, ext_oe_b = 6'h3F;
    int          num_errors = 0, check_count = 0, cycles = 0;

    bpc_port #(.WIDTH(6)) u_bpc_port (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_b(pin_oe_b), .alt_out(alt_out),
        .alt_oe_b(alt_oe_b), .irq(irq));
    bpc_pin_model #(.WIDTH(6)) u_bpc_pin_model (.pin_out(pin_out),
        .pin_oe_b(pin_oe_b), .ext_val(ext_val), .ext_oe_b(ext_oe_b), .pin_in(pin_in));

    // clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            complete_run;
        end
    end

    // ***************************************************************
    // shared tasks
    // ***************************************************************
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; request held until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdata);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ***************************************************************
    // scenarios
    // ***************************************************************
    task automatic t_reset;
        cyc(1);
        chk("oe_b_rst", 32'h3F, {26'h0, pin_oe_b});
        rd("dir_rst", `BPC_OFF_DIR, 32'h3F);
        rd("latch_rst", `BPC_OFF_LATCH, 32'h0);
    endtask

    task automatic t_dir_latch;
        ext_val <= 6'h08;
        ext_oe_b <= 6'h37;
        wr(`BPC_OFF_LATCH, 32'h15);
        wr(`BPC_OFF_DIR, 32'h0);
        rd("dir_in_only", `BPC_OFF_DIR, 32'h08);
        cyc(8);
        chk("oe_b_out", 32'h08, {26'h0, pin_oe_b});
        chk("pin_out", 32'h15, {26'h0, pin_out & 6'h37});
        rd("level", `BPC_OFF_LEVEL, 32'h1D);
        rd("latch", `BPC_OFF_LATCH, 32'h15);
        wr(`BPC_OFF_LEVEL, 32'h2A);
        rd("latch_wr", `BPC_OFF_LATCH, 32'h2A);
        cyc(2);
        chk("pin_out_wr", 32'h22, {26'h0, pin_out & 6'h37});
    endtask

    task automatic t_alt;
        wr(`BPC_OFF_ALT_EN, 32'h01);
        alt_out <= 6'h01;
        alt_oe_b <= 6'h3E;
        cyc(3);
        chk("alt_drive", 32'h1, {31'h0, pin_out[0] ^ pin_oe_b[0]});
        @(posedge clk);
        alt_oe_b <= 6'h3F;
        cyc(3);
        chk("alt_release", 32'h1, {31'h0, pin_oe_b[0]});
        wr(`BPC_OFF_ALT_EN, 32'h0);
        cyc(3);
        chk("gpio_back", 32'h0, {30'h0, pin_out[0], pin_oe_b[0]});
    endtask

    task automatic t_change;
        wr(`BPC_OFF_DIR, 32'h3F);
        ext_oe_b <= 6'h00;
        ext_val <= 6'h00;
        cyc(8);
        rd("level0", `BPC_OFF_LEVEL, 32'h0);
        wr(`BPC_OFF_CHG_EN, 32'h3F);
        wr(`BPC_OFF_CTRL, 32'h1);
        wr(`BPC_OFF_IRQ_EN, 32'h1);
        ext_val <= 6'h04;
        cyc(8);
        chk("irq_set", 32'h1, {31'h0, irq});
        rd("flag_set", `BPC_OFF_IRQ_STAT, 32'h1);
        rd("level4", `BPC_OFF_LEVEL, 32'h04);
        rd("flag_sticky", `BPC_OFF_IRQ_STAT, 32'h1);
        wr(`BPC_OFF_IRQ_EN, 32'h0);
        cyc(2);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(`BPC_OFF_IRQ_CLR, 32'h1);
        rd("flag_clr", `BPC_OFF_IRQ_STAT, 32'h0);
        wr(`BPC_OFF_IRQ_EN, 32'h1);
        wr(`BPC_OFF_CHG_EN, 32'h3E);
        rd("chg_en_rb", `BPC_OFF_CHG_EN, 32'h3E);
        ext_val <= 6'h05;
        cyc(8);
        rd("pin_disabled", `BPC_OFF_IRQ_STAT, 32'h0);
        wr(`BPC_OFF_CTRL, 32'h0);
        ext_val <= 6'h07;
        cyc(8);
        rd("global_off", `BPC_OFF_IRQ_STAT, 32'h0);
        rd("level7", `BPC_OFF_LEVEL, 32'h07);
        wr(`BPC_OFF_CTRL, 32'h1);
        wr(`BPC_OFF_LATCH, 32'h0);
        wr(`BPC_OFF_DIR, 32'h3D);
        cyc(8);
        rd("output_excl", `BPC_OFF_IRQ_STAT, 32'h0);
        rd("level5", `BPC_OFF_LEVEL, 32'h05);
        ext_val <= 6'h25;
        cyc(8);
        rd("or_flag", `BPC_OFF_IRQ_STAT, 32'h1);
        chk("irq_or", 32'h1, {31'h0, irq});
        rd("ctrl_flag", `BPC_OFF_CTRL, 32'h3);
        rd("level25", `BPC_OFF_LEVEL, 32'h25);
        wr(`BPC_OFF_CTRL, 32'h1);
        rd("ctrl_clr", `BPC_OFF_CTRL, 32'h1);
    endtask

    task automatic t_unmapped;
        rd("alt_en_rb", `BPC_OFF_ALT_EN, 32'h0);
        chk("mapped_err", 32'h0, {31'h0, rerr});
        rd("unmapped_data", 12'h024, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, rerr});
    endtask

    // ***************************************************************
    // main sequence
    // ***************************************************************
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_dir_latch;
        t_alt;
        t_change;
        t_unmapped;
        complete_run;
    end
endmodule
